// ===== rtl/trace_pkg.sv
`default_nettype none
package trace_pkg;

    // Register byte offsets on the APB.
    localparam logic [7:0] CONFIG_OFS = 8'h00;
    localparam logic [7:0] CONTROL_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] COUNT_OFS = 8'h0C;
    localparam logic [7:0] FIFO_OFS = 8'h10;
    localparam logic [7:0] CMPA_OFS = 8'h14;
    localparam logic [7:0] CMPB_OFS = 8'h18;

    // Field positions in trigger_config_reg.
    localparam int CFG_BEGIN_BIT = 7;
    localparam int CFG_QUAL_BIT = 6;
    // Field positions in trace_control_reg.
    localparam int CTL_EN_BIT = 7;
    localparam int CTL_ARM_BIT = 6;
    localparam int CTL_TAG_BIT = 5;
    localparam int CTL_BRK_BIT = 4;
    // Field positions in trace_status_reg.
    localparam int STS_AF_BIT = 7;
    localparam int STS_BF_BIT = 6;
    localparam int STS_CF_BIT = 5;
    localparam int STS_ARMED_BIT = 0;

    // Widths and sizes.
    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;
    localparam int DEPTH = 8;
    localparam int PTR_W = 3;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_FULL = 4'h8;
    localparam logic [CNT_W-1:0] CNT_LAST = 4'h7;
    localparam logic [ADDR_W-1:0] BRANCH_BACK = 17'h00002;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // Trigger modes kept by this block.
    typedef enum logic [3:0] {
        MODE_A_ONLY = 4'h0,
        MODE_EVENT_B = 4'h3,
        MODE_A_AND_NOT_B = 4'h6,
        MODE_INSIDE = 4'h7,
        MODE_OUTSIDE = 4'h8
    } trig_mode_e;

    // Capture states, Gray coded along idle, wait, capture, end.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_CAPT = 2'b11,
        ST_END = 2'b10
    } cap_state_e;

    // Signals from the CPU core, all on the core clock.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic valid;
        logic [1:0] cof;
        logic execValid;
        logic [ADDR_W-1:0] execAddr;
        logic matchC;
    } core_bus_s;

    // Break requests back to the core.
    typedef struct packed {
        logic forceReq;
        logic tag;
    } break_req_s;

endpackage : trace_pkg
`default_nettype wire

// ===== rtl/trace_trigger_fifo_capture.sv
// Notes on behaviour
// (R1) A-and-not-B: A on address, B on data; flags only when A hits, B misses.
// (R2) A-and-not-B: lone A hit or lone B miss sets no flag.
// (R3) Tag break in end run under A-and-not-B uses comparator A alone.
// (R4) Inside range: both flags when A <= address <= B, otherwise none.
// (R5) Outside range: A flag below A, B flag above B.
// (R6) End run without break fills buffer until trigger, CPU keeps running.
// (R7) End run with break: force at address trigger, tag at opcode trigger.
// (R8) Begin run starts filling at trigger; force break when buffer full.
// (R9) Break kind is ignored while CPU breaks are disabled.
// (R10) Controller should keep qualification equal to break kind in end runs.
// (R11) Controller should not pick tag break in begin runs.
// (R12) Trace buffer holds eight words, first in first out.
// (R13) Store flow addresses, or only event data in event-only modes.
// (R14) Event-only reads give zero high byte and zero extended byte.
// (R15) Destination indicator stores the current core address.
// (R16) Taken-branch indicator stores previous registered address minus two.
// (R17) Begin run stores nothing before trigger, then stays armed for 8 words.
// (R18) Begin capture in all modes; end capture not in event-only modes.
// (R19) End run stores while armed; trigger clears arm and stops storing.
// (R20) End run stores the triggering flow event itself.
// (R21) Arming clears comparator A, B and C flags.
// (R22) Begin run clears arm when the buffer becomes full.
// (R23) End run overwrites the oldest word once eight are held.
// (R24) With qualification, a match triggers only once the opcode executed.
// (R25) Write pointer wraps at eight, valid count saturates at eight.
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module trace_trigger_fifo_capture (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire trace_pkg::core_bus_s core,
    output var trace_pkg::break_req_s brk
);

    // Comparator flags for a given address and data under the chosen mode.
    function automatic logic [1:0] evalHits(
        input logic [3:0] mode,
        input logic [trace_pkg::ADDR_W-1:0] adr,
        input logic [trace_pkg::DATA_W-1:0] dat,
        input logic [trace_pkg::ADDR_W-1:0] cmpA,
        input logic [trace_pkg::ADDR_W-1:0] cmpB);
        logic [1:0] r;
        r = 2'b00;
        case (mode)
            trace_pkg::MODE_A_ONLY: r = {adr == cmpA, 1'b0};
            trace_pkg::MODE_EVENT_B: r = {1'b0, adr == cmpB};
            trace_pkg::MODE_A_AND_NOT_B: begin
                r = {2{(adr == cmpA) && (dat != cmpB[trace_pkg::DATA_W-1:0])}}; // [R1] [R2]
            end
            trace_pkg::MODE_INSIDE: r = {2{(adr >= cmpA) && (adr <= cmpB)}}; // [R4]
            trace_pkg::MODE_OUTSIDE: r = {adr < cmpA, adr > cmpB}; // [R5]
            default: r = 2'b00;
        endcase
        return r;
    endfunction : evalHits

    logic [7:0] cfgQ;
    logic enQ, tagQ, brkEnQ;
    logic aFlagQ, bFlagQ, cFlagQ;
    logic [trace_pkg::ADDR_W-1:0] cmpAQ, cmpBQ, prevAddrQ;
    logic [trace_pkg::ADDR_W-1:0] mem [trace_pkg::DEPTH];
    logic [trace_pkg::PTR_W-1:0] wrPtrQ, rdOffQ;
    logic [trace_pkg::CNT_W-1:0] cntQ;
    trace_pkg::cap_state_e stateQ, stateD;

    // APB decode: the write or read takes effect at the single access edge.
    logic accessEdge, wrEdge, rdEdge, armWrite;
    assign accessEdge = psel && penable && pready;
    assign wrEdge = accessEdge && pwrite;
    assign rdEdge = accessEdge && !pwrite;
    assign armWrite = wrEdge && (paddr == trace_pkg::CONTROL_OFS) &&
                      pwdata[trace_pkg::CTL_ARM_BIT] && pwdata[trace_pkg::CTL_EN_BIT];

    // Mode decode; event-only modes always run as begin captures.
    logic [3:0] mode;
    logic eventMode, beginRun, qualSel, armed;
    assign mode = cfgQ[3:0];
    assign eventMode = (mode == trace_pkg::MODE_EVENT_B);
    assign beginRun = cfgQ[trace_pkg::CFG_BEGIN_BIT] || eventMode; // [R18]
    assign qualSel = cfgQ[trace_pkg::CFG_QUAL_BIT] && !eventMode;
    assign armed = (stateQ != trace_pkg::ST_IDLE);

    // Trigger evaluation on the bus cycle or on the executed opcode.
    logic [1:0] busHits, exeHits, hits;
    logic trig, tagHit;
    assign busHits = core.valid ?
        evalHits(mode, core.addr, core.data, cmpAQ, cmpBQ) : 2'b00;
    assign exeHits = core.execValid ?
        evalHits(mode, core.execAddr, core.data, cmpAQ, cmpBQ) : 2'b00;
    assign hits = qualSel ? exeHits : busHits; // [R24]
    assign trig = armed && (|hits);
    // Tagging in A-and-not-B follows comparator A only, B is ignored.
    assign tagHit = (mode == trace_pkg::MODE_A_AND_NOT_B) ?
        (core.execValid && (core.execAddr == cmpAQ)) : (|exeHits); // [R3]

    // What a store would write in this cycle.
    logic storeReq;
    logic [trace_pkg::ADDR_W-1:0] storeWord;
    always_comb begin
        storeReq = 1'b0;
        storeWord = core.addr;
        if (eventMode) begin
            storeReq = busHits[0]; // [R13]
            storeWord = {{(trace_pkg::ADDR_W-trace_pkg::DATA_W){1'b0}}, core.data}; // [R14]
        end else if (core.cof[1]) begin
            storeReq = 1'b1;
            storeWord = core.addr; // [R15]
        end else if (core.cof[0]) begin
            storeReq = 1'b1;
            storeWord = prevAddrQ - trace_pkg::BRANCH_BACK; // [R16]
        end
    end

    // Capture sequencing; the store enable follows from the state.
    logic doStore, full;
    always_comb begin
        stateD = stateQ;
        doStore = 1'b0;
        case (stateQ)
            trace_pkg::ST_IDLE: stateD = trace_pkg::ST_IDLE;
            trace_pkg::ST_WAIT: begin
                if (trig) begin
                    doStore = storeReq; // [R8] [R17]
                    stateD = trace_pkg::ST_CAPT;
                end
            end
            trace_pkg::ST_CAPT: doStore = storeReq; // [R17]
            trace_pkg::ST_END: begin
                doStore = storeReq; // [R6] [R19] [R20]
                if (trig) begin
                    stateD = trace_pkg::ST_IDLE; // [R19]
                end
            end
            default: stateD = trace_pkg::ST_IDLE;
        endcase
        full = doStore && (cntQ == trace_pkg::CNT_LAST) &&
               (stateQ == trace_pkg::ST_CAPT || stateQ == trace_pkg::ST_WAIT);
        if (full) begin
            stateD = trace_pkg::ST_IDLE; // [R22]
        end
        if (wrEdge && paddr == trace_pkg::CONTROL_OFS) begin
            if (armWrite) begin
                stateD = beginRun ? trace_pkg::ST_WAIT : trace_pkg::ST_END;
            end else if (!pwdata[trace_pkg::CTL_ARM_BIT] || !pwdata[trace_pkg::CTL_EN_BIT]) begin
                stateD = trace_pkg::ST_IDLE;
            end
        end
    end

    // Capture state register.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            stateQ <= trace_pkg::ST_IDLE;
        end else begin
            stateQ <= stateD;
        end
    end

    // Address registered on every valid bus cycle, the base for taken-branch sources.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            prevAddrQ <= '0;
        end else if (core.valid) begin
            prevAddrQ <= core.addr;
        end
    end

    // Eight-word buffer; the pointer simply wraps so the oldest word is overwritten.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            wrPtrQ <= '0;
            cntQ <= '0;
        end else if (armWrite) begin
            wrPtrQ <= '0;
            cntQ <= '0;
        end else if (doStore) begin
            mem[wrPtrQ] <= storeWord; // [R12] [R23]
            wrPtrQ <= wrPtrQ + 3'h1; // [R25]
            if (cntQ != trace_pkg::CNT_FULL) begin
                cntQ <= cntQ + 4'h1; // [R25]
            end
        end
    end

    // Readout offset advances only on reads while not armed, so an armed read
    // returns the oldest word without disturbing capture.
    logic [trace_pkg::PTR_W-1:0] oldest, rdIdx;
    assign oldest = (cntQ == trace_pkg::CNT_FULL) ? wrPtrQ : '0;
    assign rdIdx = oldest + rdOffQ;
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rdOffQ <= '0;
        end else if (armWrite) begin
            rdOffQ <= '0;
        end else if (rdEdge && paddr == trace_pkg::FIFO_OFS && !armed) begin
            rdOffQ <= rdOffQ + 3'h1;
        end
    end

    // Comparator flags; arming clears them, but a match in that cycle still sets if the block was already armed.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            aFlagQ <= 1'b0;
            bFlagQ <= 1'b0;
            cFlagQ <= 1'b0;
        end else begin
            aFlagQ <= (aFlagQ && !armWrite) || (trig && hits[1]); // [R1] [R4] [R5] [R21]
            bFlagQ <= (bFlagQ && !armWrite) || (trig && hits[0]); // [R1] [R4] [R5] [R21]
            cFlagQ <= (cFlagQ && !armWrite) || (armed && core.matchC); // [R21]
        end
    end

    // Break requests are one-cycle pulses; none while breaks are disabled.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            brk <= '0;
        end else begin
            brk.forceReq <= brkEnQ && !tagQ && ((stateQ == trace_pkg::ST_END && trig && !qualSel) ||
                         full); // [R7] [R8] [R9]
            brk.tag <= brkEnQ && tagQ && qualSel && stateQ == trace_pkg::ST_END &&
                       tagHit; // [R3] [R7] [R9]
        end
    end

    // Software-written configuration.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            cfgQ <= trace_pkg::ZERO_BYTE;
            enQ <= 1'b0;
            tagQ <= 1'b0;
            brkEnQ <= 1'b0;
            cmpAQ <= '0;
            cmpBQ <= '0;
        end else if (wrEdge) begin
            case (paddr)
                trace_pkg::CONFIG_OFS: cfgQ <= pwdata[7:0];
                trace_pkg::CONTROL_OFS: begin
                    enQ <= pwdata[trace_pkg::CTL_EN_BIT];
                    tagQ <= pwdata[trace_pkg::CTL_TAG_BIT];
                    brkEnQ <= pwdata[trace_pkg::CTL_BRK_BIT];
                end
                trace_pkg::CMPA_OFS: cmpAQ <= pwdata[trace_pkg::ADDR_W-1:0];
                trace_pkg::CMPB_OFS: cmpBQ <= pwdata[trace_pkg::ADDR_W-1:0];
                default: cfgQ <= cfgQ;
            endcase
        end
    end

    // Read data mux, sampled at the setup edge for a registered answer.
    logic [31:0] rdMux;
    logic mapped;
    logic [trace_pkg::ADDR_W-1:0] fifoWord;
    assign fifoWord = mem[rdIdx];
    always_comb begin
        rdMux = '0;
        mapped = 1'b1;
        case (paddr)
            trace_pkg::CONFIG_OFS: rdMux[7:0] = cfgQ;
            trace_pkg::CONTROL_OFS: begin
                rdMux[trace_pkg::CTL_EN_BIT] = enQ;
                rdMux[trace_pkg::CTL_ARM_BIT] = armed;
                rdMux[trace_pkg::CTL_TAG_BIT] = tagQ;
                rdMux[trace_pkg::CTL_BRK_BIT] = brkEnQ;
            end
            trace_pkg::STATUS_OFS: begin
                rdMux[trace_pkg::STS_AF_BIT] = aFlagQ;
                rdMux[trace_pkg::STS_BF_BIT] = bFlagQ;
                rdMux[trace_pkg::STS_CF_BIT] = cFlagQ;
                rdMux[trace_pkg::STS_ARMED_BIT] = armed;
            end
            trace_pkg::COUNT_OFS: rdMux[trace_pkg::CNT_W-1:0] = cntQ;
            trace_pkg::FIFO_OFS: begin
                // Low, high and extended bytes; event data carries zeros above.
                rdMux[23:0] = eventMode ? {trace_pkg::ZERO_BYTE, trace_pkg::ZERO_BYTE, fifoWord[7:0]} :
                              {7'h00, fifoWord}; // [R14]
            end
            trace_pkg::CMPA_OFS: rdMux[trace_pkg::ADDR_W-1:0] = cmpAQ;
            trace_pkg::CMPB_OFS: rdMux[trace_pkg::ADDR_W-1:0] = cmpBQ;
            default: mapped = 1'b0;
        endcase
    end

    // One wait-free access phase: pready rises for exactly the first access cycle.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (psel && !penable && !pwrite) begin
                prdata <= rdMux;
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    sequence s_andNotBHit;
        armed && mode == trace_pkg::MODE_A_AND_NOT_B && !qualSel && core.valid &&
        core.addr == cmpAQ && core.data != cmpBQ[7:0];
    endsequence
    sequence s_flagsBoth;
        aFlagQ && bFlagQ;
    endsequence

    property p_andNotB;
        s_andNotBHit |=> s_flagsBoth;
    endproperty
    a_andNotB: assert property (p_andNotB) else $error("A and not B did not set both flags"); // [R1]

    property p_andNotBLone;
        (mode == trace_pkg::MODE_A_AND_NOT_B && !qualSel && !aFlagQ && !armWrite &&
         core.valid && core.data == cmpBQ[7:0]) |=> !aFlagQ;
    endproperty
    a_andNotBLone: assert property (p_andNotBLone) else $error("flag set without B miss"); // [R2]

    property p_inside;
        (armed && mode == trace_pkg::MODE_INSIDE && !qualSel && core.valid &&
         core.addr >= cmpAQ && core.addr <= cmpBQ) |=> s_flagsBoth;
    endproperty
    a_inside: assert property (p_inside) else $error("inside range flags missing"); // [R4]

    property p_outsideLow;
        (armed && mode == trace_pkg::MODE_OUTSIDE && !qualSel && core.valid &&
         core.addr < cmpAQ) |=> aFlagQ;
    endproperty
    a_outsideLow: assert property (p_outsideLow) else $error("outside low flag missing"); // [R5]

    property p_noBreakDisabled;
        !brkEnQ |=> !brk.forceReq && !brk.tag;
    endproperty
    a_noBreakDisabled: assert property (p_noBreakDisabled) else $error("break while disabled"); // [R9]

    property p_endStop;
        (stateQ == trace_pkg::ST_END && trig && !wrEdge) |=> !armed ##1 (cntQ == $past(cntQ));
    endproperty
    a_endStop: assert property (p_endStop) else $error("end run kept storing"); // [R19]

    property p_fullBreak;
        (full && brkEnQ && !tagQ) |=> brk.forceReq && !armed && cntQ == trace_pkg::CNT_FULL;
    endproperty
    a_fullBreak: assert property (p_fullBreak) else $error("full did not break or disarm"); // [R8] [R22]

    property p_countCap;
        cntQ <= trace_pkg::CNT_FULL;
    endproperty
    a_countCap: assert property (p_countCap) else $error("valid count above eight"); // [R25]

    property p_armClears;
        (armWrite && !core.valid && !core.matchC) |=> !aFlagQ && !bFlagQ && !cFlagQ;
    endproperty
    a_armClears: assert property (p_armClears) else $error("arming left a flag set"); // [R21]

    property p_waitNoStore;
        (stateQ == trace_pkg::ST_WAIT && !trig && !armWrite) |=> cntQ == $past(cntQ);
    endproperty
    a_waitNoStore: assert property (p_waitNoStore) else $error("stored before trigger"); // [R17]

    property p_branchSource;
        (doStore && !eventMode && !core.cof[1] && core.cof[0] && !armWrite) |=>
            mem[$past(wrPtrQ)] == $past(prevAddrQ) - trace_pkg::BRANCH_BACK;
    endproperty
    a_branchSource: assert property (p_branchSource) else $error("branch source wrong"); // [R16]

endmodule : trace_trigger_fifo_capture
`default_nettype wire

// ===== verif/core_model.sv
`timescale 1ns/1ns
`default_nettype none
module core_model (
    input wire logic clock,
    output var trace_pkg::core_bus_s core
);
    // The core starts with no valid cycle on its bus.
    initial begin
        core = '0;
    end

    // One bus cycle, driven right after an edge; steps may follow each other every cycle.
    task automatic step(input logic [16:0] a, input logic [7:0] d, input logic [1:0] c, input logic ex,
                        input logic [16:0] ea);
        @(posedge clock);
        core <= '{addr: a, data: d, valid: 1'b1, cof: c, execValid: ex, execAddr: ea, matchC: 1'b0};
    endtask : step

    // Released lines invert, so a stale address can never pass for a fresh match.
    task automatic idle();
        @(posedge clock);
        core <= '{addr: ~core.addr, data: ~core.data, valid: 1'b0, cof: 2'b00, execValid: 1'b0,
                  execAddr: ~core.execAddr, matchC: 1'b0};
    endtask : idle

    // One cycle of a comparator C match with no bus cycle, so the C flag can be reached.
    task automatic cHit();
        @(posedge clock);
        core <= '{addr: ~core.addr, data: ~core.data, valid: 1'b0, cof: 2'b00, execValid: 1'b0,
                  execAddr: ~core.execAddr, matchC: 1'b1};
    endtask : cHit
endmodule : core_model
`default_nettype wire

// ===== verif/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clock;
    logic rst_b;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] rdat;
    logic rerr;
    logic [16:0] a;
    logic [16:0] pa;
    trace_pkg::core_bus_s core;
    trace_pkg::break_req_s brk;
    int fail_count;
    int checks_done;
    int nForce;
    int nTag;
    int f0;
    int t0;
    int i;
    int m;
    logic [31:0] expq[$];
    logic [3:0] tMode [9] = '{4'h6, 4'h6, 4'h6, 4'h7, 4'h7, 4'h7, 4'h8, 4'h8, 4'h8};
    logic [16:0] tAddr [9] = '{17'h100, 17'h180, 17'h100, 17'h080, 17'h200, 17'h100, 17'h100, 17'h0FF, 17'h201};
    logic [7:0] tData [9] = '{8'h5A, 8'h11, 8'h11, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [16:0] tB [9] = '{17'h5A, 17'h5A, 17'h5A, 17'h200, 17'h200, 17'h200, 17'h200, 17'h200, 17'h200};
    logic [1:0] tExp [9] = '{2'b00, 2'b00, 2'b11, 2'b00, 2'b11, 2'b11, 2'b00, 2'b10, 2'b01};

    trace_trigger_fifo_capture i_dut (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .core(core), .brk(brk));
    core_model i_core (.clock(clock), .core(core));

    // Free-running core clock at 250 MHz.
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // Break pulses last one cycle, so they are counted mid-cycle, where they have settled.
    always @(negedge clock) begin
        if (brk.forceReq === 1'b1) nForce++;
        if (brk.tag === 1'b1) nTag++;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // One APB transfer; the request holds until pready is seen high at an edge.
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1 && n < 40) begin
            @(posedge clock);
            n++;
        end
        chk({31'h0, pready}, 32'h1, "apb answer");
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        apb(1'b1, ad, d);
    endtask : wr

    task automatic rd(input logic [7:0] ad);
        apb(1'b0, ad, 32'h0);
    endtask : rd

    // Configure first, then arm, so the run starts under the new mode.
    task automatic arm(input logic [31:0] cfg, input logic [31:0] ctl);
        wr(trace_pkg::CONFIG_OFS, cfg);
        wr(trace_pkg::CONTROL_OFS, ctl);
        f0 = nForce;
        t0 = nTag;
    endtask : arm

    task automatic final_report();
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    // A hang is cut short well beyond the few hundred cycles the tests need.
    initial begin
        repeat (20000) @(posedge clock);
        fail_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        final_report();
    end

    // Main sequence of tests.
    initial begin
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (6) @(posedge clock);
        rst_b <= 1'b1;
        rd(trace_pkg::STATUS_OFS);
        chk(rdat, 32'h0, "status after reset");
        rd(trace_pkg::COUNT_OFS);
        chk(rdat, 32'h0, "count after reset");
        rd(8'h1C);
        chk({31'h0, rerr}, 32'h1, "unmapped error");
        chk(rdat, 32'h0, "unmapped data");
        $display("test reset done");

        // Comparator flag table; each row re-arms, which must clear the flags first.
        wr(trace_pkg::CMPA_OFS, 32'h100);
        for (i = 0; i < 9; i++) begin
            wr(trace_pkg::CMPB_OFS, {15'h0, tB[i]});
            arm({28'h0, tMode[i]}, 32'hC0);
            rd(trace_pkg::STATUS_OFS);
            chk({29'h0, rdat[7:5]}, 32'h0, "flags after arm");
            // Comparator C is hit in every row, so the next arm must clear all three flags.
            i_core.cHit();
            i_core.step(tAddr[i], tData[i], 2'b00, 1'b0, 17'h0);
            i_core.idle();
            rd(trace_pkg::STATUS_OFS);
            chk({29'h0, rdat[7:5]}, {29'h0, tExp[i], 1'b1}, "flags");
        end
        $display("test flags done");

        // End run with force break: ten flow events, then the trigger on a flow event.
        wr(trace_pkg::CMPA_OFS, 32'h200);
        arm(32'h00, 32'hD0);
        expq.delete();
        for (i = 0; i < 10; i++) begin
            a = 17'h100 + 17'(16 * i);
            i_core.step(a, 8'h00, (i == 5) ? 2'b01 : 2'b10, 1'b0, 17'h0);
            expq.push_back({15'h0, (i == 5) ? pa - trace_pkg::BRANCH_BACK : a});
            pa = a;
        end
        i_core.step(17'h200, 8'h00, 2'b10, 1'b0, 17'h0);
        expq.push_back(32'h200);
        i_core.step(17'h300, 8'h00, 2'b10, 1'b0, 17'h0);
        i_core.idle();
        chk(nForce - f0, 1, "force breaks");
        chk(nTag - t0, 0, "tag breaks");
        rd(trace_pkg::STATUS_OFS);
        chk({31'h0, rdat[0]}, 32'h0, "armed after trigger");
        rd(trace_pkg::CONTROL_OFS);
        chk({31'h0, rdat[6]}, 32'h0, "arm after trigger");
        rd(trace_pkg::COUNT_OFS);
        chk(rdat, 32'h8, "count saturates");
        for (i = 0; i < 8; i++) begin
            rd(trace_pkg::FIFO_OFS);
            chk(rdat, expq[i + 3], "end run word");
        end
        $display("test end run done");

        // Qualified tag break, in A only and in A and not B with comparator B matching.
        wr(trace_pkg::CMPB_OFS, 32'h5A);
        for (m = 0; m < 2; m++) begin
            arm((m == 0) ? 32'h40 : 32'h46, 32'hF0);
            i_core.step(17'h200, 8'h5A, 2'b10, 1'b0, 17'h0);
            i_core.idle();
            rd(trace_pkg::STATUS_OFS);
            chk({31'h0, rdat[0]}, 32'h1, "armed before execution");
            chk(nTag - t0, 0, "no tag before execution");
            i_core.step(17'h210, 8'h5A, 2'b00, 1'b1, 17'h200);
            // The pulse appears one edge after execution; a second idle cycle lets it be counted.
            i_core.idle();
            i_core.idle();
            chk(nTag - t0, 1, "tag break");
            chk(nForce - f0, 0, "no force break");
        end
        $display("test qualified done");

        // Breaks disabled, with tag and then force chosen: trace ends, no break of either kind.
        for (m = 0; m < 2; m++) begin
            arm(32'h00, (m == 0) ? 32'hE0 : 32'hC0);
            i_core.step(17'h200, 8'h00, 2'b10, 1'b0, 17'h0);
            i_core.idle();
            rd(trace_pkg::STATUS_OFS);
            chk({31'h0, rdat[0]}, 32'h0, "run ended");
            chk((nTag - t0) + (nForce - f0), 0, "no breaks");
        end
        $display("test no break done");

        // Begin run: events before the trigger are dropped, then eight words fill it.
        arm(32'h80, 32'hD0);
        for (i = 0; i < 3; i++) i_core.step(17'h100 + 17'(2 * i), 8'h00, 2'b10, 1'b0, 17'h0);
        i_core.step(17'h200, 8'h00, 2'b10, 1'b0, 17'h0);
        for (i = 0; i < 9; i++) i_core.step(17'h300 + 17'(2 * i), 8'h00, 2'b10, 1'b0, 17'h0);
        i_core.idle();
        rd(trace_pkg::COUNT_OFS);
        chk(rdat, 32'h8, "begin count");
        rd(trace_pkg::STATUS_OFS);
        chk({31'h0, rdat[0]}, 32'h0, "disarmed when full");
        chk(nForce - f0, 1, "force when full");
        for (i = 0; i < 8; i++) begin
            rd(trace_pkg::FIFO_OFS);
            chk(rdat, (i == 0) ? 32'h200 : 32'h300 + 32'(2 * (i - 1)), "begin word");
        end
        $display("test begin run done");

        // Event-only mode keeps only the data byte and runs as a begin run.
        wr(trace_pkg::CMPB_OFS, 32'h220);
        arm(32'h03, 32'hC0);
        i_core.step(17'h220, 8'hA5, 2'b10, 1'b0, 17'h0);
        i_core.idle();
        rd(trace_pkg::COUNT_OFS);
        chk(rdat, 32'h1, "event count");
        rd(trace_pkg::STATUS_OFS);
        chk({30'h0, rdat[6], rdat[0]}, 32'h3, "event flag and still armed");
        rd(trace_pkg::FIFO_OFS);
        chk(rdat, 32'hA5, "event word");
        $display("test event done");
        final_report();
    end
endmodule : tb
`default_nettype wire
